/* cbi_defines.vh */
// Constants for the bus cycle and interrupt control block
// Contract
// [R1] Bus cycle runs T1, T2, T3, T4 in order
// [R2] Address in T1, turnaround T2, data T3-T4; writes drive data from T2 with no turnaround
// [R3] Not ready inserts wait states before T4
// [R4] Idle states between cycles when nothing pending
// [R5] Address latch strobe in T1, minimum mode
// [R6] Three status lines encode the cycle type
// [R7] Upper status shares top address lines, T2-T4
// [R8] Segment on two bits, enable flag bit
// [R9] I/O cycles drive top four address low
// [R10] Reset held high over four clocks
// [R11] Reset aborts, ten clocks, then fetch start
// [R12] Pointer table of 256 four-byte entries
// [R13] Non-maskable pulse lasts two clocks minimum
// [R14] Non-maskable first; serviced at boundaries only
// [R15] Maskable request held until acknowledged
// [R16] Taking interrupt saves then clears enable
// [R17] Lock from T2 first to T2 second ack
// [R18] Type byte times four gives pointer address
// [R19] Interrupt return restores the enable flag
// [R20] Halt left only by interrupt or reset
// [R21] Strobes active from T2 until T4
// [R22] Memory/I-O select valid T1 through T4
// [R23] Mode pin high selects minimum mode strobes
// [R24] No cycles, passive status during reset
`ifndef CBI_DEFINES_VH
`define CBI_DEFINES_VH

// Register byte offsets
`define CBI_OFS_ADDR 8'h00
`define CBI_OFS_WDATA 8'h04
`define CBI_OFS_CTRL 8'h08
`define CBI_OFS_FLAGS 8'h0c
`define CBI_OFS_STATUS 8'h10
`define CBI_OFS_VECTOR 8'h14

// Control register fields
`define CBI_CTRL_TYPE_LSB 0
`define CBI_CTRL_SEG_LSB 3
`define CBI_CTRL_BHE_BIT 5
`define CBI_CTRL_START_BIT 8
`define CBI_CTRL_BOUND_BIT 9
`define CBI_CTRL_HALT_BIT 10
`define CBI_CTRL_INTERRUPT_RETURN_OP_BIT 11

// Cycle type codes on the three status lines
`define CBI_CYC_ACK 3'h0
`define CBI_CYC_IORD 3'h1
`define CBI_CYC_IOWR 3'h2
`define CBI_CYC_HALT 3'h3
`define CBI_CYC_FETCH 3'h4
`define CBI_CYC_MEMRD 3'h5
`define CBI_CYC_MEMWR 3'h6
`define CBI_CYC_PASSIVE 3'h7

// Segment codes
`define CBI_SEG_EXTRA 2'h0
`define CBI_SEG_STACK 2'h1
`define CBI_SEG_CODE 2'h2
`define CBI_SEG_DATA 2'h3

// Reset values and fixed numbers
`define CBI_RST_SEQ_CLKS 4'ha
`define CBI_RESET_VECTOR 20'hffff0
`define CBI_NMI_TYPE 8'h02
`define CBI_TOP_STATUS 1'h0
`define CBI_RESP_OKAY 2'h0
`define CBI_RESP_SLVERR 2'h2

`endif

/* cbi_sync.v */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module cbi_sync
#(
  parameter WIDTH = 1
)
(
  input wire sys_clk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule // cbi_sync
`default_nettype wire

/* cbi_top.v */
// Bus cycle sequencer and interrupt control with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "cbi_defines.vh"
module cbi_top
(
  input wire sys_clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire mode_select_pin,
  input wire bus_ready,
  input wire nmi_request,
  input wire maskable_request,
  input wire [15:0] ad_in,
  output reg [15:0] ad_out,
  output reg ad_oe,
  output reg [3:0] addr_status_hi,
  output reg high_byte_enable_n,
  output reg ale,
  output reg cycle_status_bit0,
  output reg cycle_status_bit1,
  output reg cycle_status_bit2,
  output reg mem_io_sel,
  output reg read_n,
  output reg write_n,
  output reg int_ack_strobe_n,
  output reg lock_n
);

  // ==========================================================
  // Bus states
  localparam ST_TI = 6'h01;
  localparam ST_T1 = 6'h02;
  localparam ST_T2 = 6'h04;
  localparam ST_T3 = 6'h08;
  localparam ST_TW = 6'h10;
  localparam ST_T4 = 6'h20;

  // ==========================================================
  // Pin synchronisers
  wire [3:0] pin_s;
  wire [15:0] ad_s;
  wire nmi_s = pin_s[0];
  wire mreq_s = pin_s[1];
  wire rdy_s = pin_s[2];
  wire min_mode = pin_s[3];

  cbi_sync #(.WIDTH(4)) u_pin_sync
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .din({mode_select_pin, bus_ready, maskable_request, nmi_request}),
    .dout(pin_s)
  );

  // Data pins are sampled late; capture happens after T4
  cbi_sync #(.WIDTH(16)) u_ad_sync
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(ad_in),
    .dout(ad_s)
  );

  // ==========================================================
  // State
  reg [5:0] bstate;
  reg [5:0] next_bstate;
  reg go;
  reg [2:0] cur_type;
  reg [19:0] cur_addr;
  reg [1:0] cur_seg;
  reg cur_bhe_n;
  reg [15:0] cur_wdata;
  reg ack_phase;
  reg ack_run;
  reg cap_pend;
  reg [19:0] sw_addr;
  reg [15:0] sw_wdata;
  reg [2:0] sw_type;
  reg [1:0] sw_seg;
  reg sw_bhe_n;
  reg int_en;
  reg saved_en;
  reg halted;
  reg chk;
  reg nmi_d;
  reg nmi_pend;
  reg [15:0] rd_data;
  reg [7:0] vec_type;
  reg vec_valid;
  reg [3:0] rst_cnt;
  reg boot_fetch;

  wire nmi_rise = nmi_s & ~nmi_d;
  wire rst_done = (rst_cnt == 4'h0);
  wire can_launch = (bstate == ST_TI) & ~go & ~cap_pend & rst_done;
  // [R12] type indexes 4-byte table
  wire [19:0] vec_ptr = {10'h000, vec_type, 2'b00};

  // ==========================================================
  // AXI4-Lite slave
  wire wr_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire rd_take = s_axi_arvalid & ~s_axi_rvalid;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire wr_ctrl = wr_take & (s_axi_awaddr == `CBI_OFS_CTRL);
  wire wr_low = wr_ctrl & s_axi_wstrb[0];
  wire wr_cmd = wr_ctrl & s_axi_wstrb[1];
  wire cmd_start = wr_cmd & s_axi_wdata[`CBI_CTRL_START_BIT];
  wire cmd_bound = wr_cmd & s_axi_wdata[`CBI_CTRL_BOUND_BIT];
  wire cmd_halt = wr_cmd & s_axi_wdata[`CBI_CTRL_HALT_BIT];
  wire cmd_interrupt_return_op = wr_cmd & s_axi_wdata[`CBI_CTRL_INTERRUPT_RETURN_OP_BIT];
  wire [2:0] new_type = wr_low ? s_axi_wdata[2:0] : sw_type;
  wire [1:0] new_seg = wr_low ? s_axi_wdata[4:3] : sw_seg;
  wire new_bhe_n = wr_low ? s_axi_wdata[`CBI_CTRL_BHE_BIT] : sw_bhe_n;
  wire [31:0] addr_word = ({12'h000, sw_addr} & ~wmask)
                          | (s_axi_wdata & wmask);
  wire [31:0] wdat_word = ({16'h0000, sw_wdata} & ~wmask)
                          | (s_axi_wdata & wmask);
  wire wr_map = (s_axi_awaddr == `CBI_OFS_ADDR)
                | (s_axi_awaddr == `CBI_OFS_WDATA)
                | (s_axi_awaddr == `CBI_OFS_CTRL)
                | (s_axi_awaddr == `CBI_OFS_FLAGS);

  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = rd_take;

  reg [31:0] rd_mux;
  reg rd_hit;

  always @*
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `CBI_OFS_ADDR: rd_mux = {12'h000, sw_addr};
      `CBI_OFS_WDATA: rd_mux = {16'h0000, sw_wdata};
      `CBI_OFS_CTRL: rd_mux = {26'h0000000, sw_bhe_n, sw_seg, sw_type};
      `CBI_OFS_FLAGS: rd_mux = {30'h00000000, saved_en, int_en};
      // Busy until the boot fetch has been launched
      `CBI_OFS_STATUS: rd_mux = {rd_data, 10'h000, ~lock_n, vec_valid,
                                 nmi_pend, ~rst_done, halted,
                                 ~can_launch | boot_fetch};
      `CBI_OFS_VECTOR: rd_mux = {vec_type, 4'h0, vec_ptr};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CBI_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `CBI_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_take)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `CBI_RESP_OKAY : `CBI_RESP_SLVERR;
      end
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `CBI_RESP_OKAY : `CBI_RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // Control, interrupts and cycle launch
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      go <= 1'b0;
      cur_type <= `CBI_CYC_PASSIVE;
      cur_addr <= 20'h00000;
      cur_seg <= `CBI_SEG_CODE;
      cur_bhe_n <= 1'b1;
      cur_wdata <= 16'h0000;
      ack_phase <= 1'b0;
      ack_run <= 1'b0;
      cap_pend <= 1'b0;
      sw_addr <= 20'h00000;
      sw_wdata <= 16'h0000;
      sw_type <= `CBI_CYC_PASSIVE;
      sw_seg <= `CBI_SEG_CODE;
      sw_bhe_n <= 1'b1;
      int_en <= 1'b0;
      saved_en <= 1'b0;
      halted <= 1'b0;
      chk <= 1'b0;
      nmi_d <= 1'b0;
      nmi_pend <= 1'b0;
      rd_data <= 16'h0000;
      vec_type <= 8'h00;
      vec_valid <= 1'b0;
      // Abort and restart the internal sequence
      // [R11] reset aborts all
      rst_cnt <= `CBI_RST_SEQ_CLKS;
      boot_fetch <= 1'b1;
    end
    else
    begin
      go <= 1'b0;
      nmi_d <= nmi_s;
      if (!rst_done)
        rst_cnt <= rst_cnt - 4'h1;
      cap_pend <= (bstate == ST_T4);
      if (wr_take & (s_axi_awaddr == `CBI_OFS_ADDR))
        sw_addr <= addr_word[19:0];
      if (wr_take & (s_axi_awaddr == `CBI_OFS_WDATA))
        sw_wdata <= wdat_word[15:0];
      if (wr_take & (s_axi_awaddr == `CBI_OFS_FLAGS) & s_axi_wstrb[0])
        int_en <= s_axi_wdata[0];
      sw_type <= new_type;
      sw_seg <= new_seg;
      sw_bhe_n <= new_bhe_n;
      // [R19] return restores enable
      if (cmd_interrupt_return_op)
        int_en <= saved_en;
      if (cmd_bound)
        chk <= 1'b1;
      if (cmd_halt & can_launch & ~ack_run)
        halted <= 1'b1;
      if (cap_pend)
      begin
        if (cur_type == `CBI_CYC_ACK)
        begin
          if (ack_phase)
          begin
            // [R18] type byte captured
            vec_type <= ad_s[7:0];
            vec_valid <= 1'b1;
            ack_run <= 1'b0;
            ack_phase <= 1'b0;
          end
          else
          begin
            ack_phase <= 1'b1;
            go <= 1'b1;
          end
        end
        else
          rd_data <= ad_s;
      end
      if (can_launch & ~ack_run)
      begin
        // [R11] fetch from start address
        if (boot_fetch)
        begin
          boot_fetch <= 1'b0;
          go <= 1'b1;
          cur_type <= `CBI_CYC_FETCH;
          cur_addr <= `CBI_RESET_VECTOR;
          cur_seg <= `CBI_SEG_CODE;
          cur_bhe_n <= 1'b0;
        end
        // [R14] checked at boundary only
        else if (chk | halted)
        begin
          chk <= 1'b0;
          // [R14] non-maskable wins
          if (nmi_pend)
          begin
            nmi_pend <= 1'b0;
            halted <= 1'b0;
            // [R16] save then clear enable
            saved_en <= int_en;
            int_en <= 1'b0;
            vec_type <= `CBI_NMI_TYPE;
            vec_valid <= 1'b1;
          end
          // [R15] level request, masked by flag
          else if (mreq_s & int_en)
          begin
            halted <= 1'b0;
            saved_en <= int_en;
            int_en <= 1'b0;
            vec_valid <= 1'b0;
            ack_run <= 1'b1;
            go <= 1'b1;
            cur_type <= `CBI_CYC_ACK;
            cur_addr <= 20'h00000;
            cur_bhe_n <= 1'b0;
          end
        end
        // [R20] halted refuses new cycles
        else if (cmd_start & ~halted)
        begin
          go <= 1'b1;
          cur_type <= new_type;
          cur_seg <= new_seg;
          cur_bhe_n <= new_bhe_n;
          cur_wdata <= sw_wdata;
          // [R9] I/O forces top lines low
          if (new_type == `CBI_CYC_IORD || new_type == `CBI_CYC_IOWR)
            cur_addr <= {4'h0, sw_addr[15:0]};
          else
            cur_addr <= sw_addr;
        end
      end
      // Edge seen in the clear cycle is kept
      // [R13] edge on synchronised pin
      if (nmi_rise)
        nmi_pend <= 1'b1;
    end
  end

  // ==========================================================
  // Bus sequencer
  always @*
  begin
    case (bstate)
      // [R4] idle until a cycle is launched
      ST_TI: next_bstate = go ? ST_T1 : ST_TI;
      // [R1] fixed order of states
      ST_T1: next_bstate = ST_T2;
      ST_T2: next_bstate = ST_T3;
      // [R3] wait while not ready
      ST_T3: next_bstate = rdy_s ? ST_T4 : ST_TW;
      ST_TW: next_bstate = rdy_s ? ST_T4 : ST_TW;
      ST_T4: next_bstate = ST_TI;
      default: next_bstate = ST_TI;
    endcase
  end

  wire in_cyc = (next_bstate != ST_TI);
  wire n_t1 = (next_bstate == ST_T1);
  wire n_t2 = (next_bstate == ST_T2);
  wire n_t4 = (next_bstate == ST_T4);
  wire n_strobe = in_cyc & ~n_t1 & ~n_t4;
  wire cyc_wr = (cur_type == `CBI_CYC_IOWR) | (cur_type == `CBI_CYC_MEMWR);
  wire cyc_ack = (cur_type == `CBI_CYC_ACK);

  // Pins follow the next state so that they come from flops
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bstate <= ST_TI;
      ad_out <= 16'h0000;
      ad_oe <= 1'b0;
      addr_status_hi <= 4'h0;
      high_byte_enable_n <= 1'b1;
      ale <= 1'b0;
      // [R24] passive while in reset
      cycle_status_bit0 <= 1'b1;
      cycle_status_bit1 <= 1'b1;
      cycle_status_bit2 <= 1'b1;
      mem_io_sel <= 1'b1;
      read_n <= 1'b1;
      write_n <= 1'b1;
      int_ack_strobe_n <= 1'b1;
      lock_n <= 1'b1;
    end
    else
    begin
      bstate <= next_bstate;
      // [R5] strobe in T1, minimum mode
      // [R23] bus controller makes it otherwise
      ale <= n_t1 & min_mode;
      // [R2] address T1, then data; writes drive it from T2, reads float T2
      ad_out <= n_t1 ? cur_addr[15:0] : cur_wdata;
      ad_oe <= n_t1 | (in_cyc & cyc_wr);
      // [R7] address in T1, status T2-T4
      // [R8] segment and enable flag
      addr_status_hi <= n_t1 ? cur_addr[19:16]
                      : {`CBI_TOP_STATUS, int_en, cur_seg};
      high_byte_enable_n <= n_t1 ? cur_bhe_n : `CBI_TOP_STATUS;
      // [R6] type code until T4
      {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0} <=
        (in_cyc & ~n_t4) ? cur_type : `CBI_CYC_PASSIVE;
      // [R22] select held T1 through T4
      if (n_t1)
        mem_io_sel <= cur_type[2];
      // [R21] strobes from T2 to T4
      read_n <= ~(n_strobe & min_mode & ~cyc_wr & ~cyc_ack);
      write_n <= ~(n_strobe & min_mode & cyc_wr);
      int_ack_strobe_n <= ~(n_strobe & min_mode & cyc_ack);
      // [R17] lock spans the two acks
      if (n_t2 & (bstate == ST_T1) & cyc_ack)
        lock_n <= ack_phase;
    end
  end

endmodule // cbi_top
`default_nettype wire

/* cbi_bus_model.sv */
// Behavioural memory, I/O space and interrupt controller on the far side
`timescale 1ns/1ps
`default_nettype none
module cbi_bus_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cycle_status_bit0,
  input wire logic cycle_status_bit1,
  input wire logic cycle_status_bit2,
  input wire logic wait_req,
  input wire logic [15:0] rd_value,
  output logic bus_ready,
  output logic [15:0] ad_in
);
  wire [2:0] st = {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0};
  // Fetch, reads and acknowledge all want data back
  wire rd_kind = st == 3'h0 || st == 3'h1 || st[2:1] == 2'b10;
  logic [2:0] wcnt;
  always @(posedge sys_clk)
  begin
    // Cycle age; a slow access turns ready after three cycles
    if (rst || st == 3'h7)
      wcnt <= 3'h0;
    else if (wcnt != 3'h7)
      wcnt <= wcnt + 3'h1;
    bus_ready <= rst || !wait_req || wcnt >= 3'h2;
    if (rst)
      ad_in <= 16'h0;
    else
      ad_in <= rd_kind ? rd_value : ~ad_in;
  end
endmodule // cbi_bus_model
`default_nettype wire

/* cbi_monitor.sv */
// Pin-level checker for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module cbi_monitor
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic mode_select_pin,
  input wire logic bus_ready,
  input wire logic [15:0] ad_out,
  input wire logic ad_oe,
  input wire logic [3:0] addr_status_hi,
  input wire logic high_byte_enable_n,
  input wire logic ale,
  input wire logic cycle_status_bit0,
  input wire logic cycle_status_bit1,
  input wire logic cycle_status_bit2,
  input wire logic mem_io_sel,
  input wire logic read_n,
  input wire logic write_n,
  input wire logic int_ack_strobe_n,
  input wire logic lock_n
);
  wire [2:0] cyc = {cycle_status_bit2, cycle_status_bit1, cycle_status_bit0};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence boot_idle;
    (!ale && cyc == 3'h7)[*8];
  endsequence
  sequence rd_t1;
    ale && cyc == 3'h5;
  endsequence
  // Ready seen low through T1..T3 must stretch the strobe
  sequence slow_t1;
    (ale && !bus_ready) ##1 !bus_ready [*2];
  endsequence
  sequence ack1;
    ale && cyc == 3'h0 && lock_n;
  endsequence
  boot_quiet_a: assert property ($fell(rst) |-> boot_idle)
    else $error("Bus active during reset sequence");
  boot_fetch_a: assert property ($fell(rst) |-> ##[9:14]
    (ale && cyc == 3'h4 && ad_out == 16'hfff0 && addr_status_hi == 4'hf))
    else $error("No start fetch after reset");
  read_strobe_a: assert property (rd_t1 |=>
    (!read_n && !ad_oe)[*2] ##[1:40] read_n)
    else $error("Read strobe or turnaround wrong");
  write_data_a: assert property (ale && cyc == 3'h6 |=>
    (!write_n && ad_oe)[*2])
    else $error("Write data or strobe wrong");
  wait_stretch_a: assert property (slow_t1 |=>
    !(read_n && write_n && int_ack_strobe_n))
    else $error("No wait state inserted");
  io_top_a: assert property (ale && (cyc == 3'h1 || cyc == 3'h2) |->
    addr_status_hi == 4'h0)
    else $error("Upper address not low on I/O");
  status_mux_a: assert property (ale |=> !addr_status_hi[3] &&
    !high_byte_enable_n && cyc == $past(cyc))
    else $error("Status not held after T1");
  mem_io_a: assert property (ale && cyc != 3'h3 |=>
    (mem_io_sel == $past(cycle_status_bit2))[*3])
    else $error("Memory select not held");
  lock_span_a: assert property (ack1 |=> (!lock_n)[*4] ##[1:20] lock_n)
    else $error("Lock span wrong");
  max_quiet_a: assert property ((!mode_select_pin)[*5] |->
    !ale && read_n && write_n && int_ack_strobe_n)
    else $error("Strobes active in maximum mode");
endmodule // cbi_monitor
`default_nettype wire

/* test_cbi_top.sv */
// Self-checking bench for the bus cycle and interrupt control block
`timescale 1ns/1ps
`default_nettype none
`include "cbi_defines.vh"
module test_cbi_top;
  logic sys_clk = 0, rst = 1, mode_select_pin = 1, wait_req = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, v;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic nmi_request = 0, maskable_request = 0;
  logic [15:0] rd_value = 0;
  logic [1:0] r;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, bus_ready, ad_oe, high_byte_enable_n, ale, mem_io_sel;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire cycle_status_bit0, cycle_status_bit1, cycle_status_bit2;
  wire read_n, write_n, int_ack_strobe_n, lock_n;
  wire [15:0] ad_in, ad_out;
  wire [3:0] addr_status_hi;
  int err_total = 0, n_checks = 0, cycles = 0;
  cbi_top dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mode_select_pin, .bus_ready, .nmi_request, .maskable_request, .ad_in,
    .ad_out, .ad_oe, .addr_status_hi, .high_byte_enable_n, .ale,
    .cycle_status_bit0, .cycle_status_bit1, .cycle_status_bit2, .mem_io_sel,
    .read_n, .write_n, .int_ack_strobe_n, .lock_n);
  cbi_bus_model bus (.sys_clk, .rst, .cycle_status_bit0, .cycle_status_bit1,
    .cycle_status_bit2, .wait_req, .rd_value, .bus_ready, .ad_in);
  initial forever #2.5 sys_clk = ~sys_clk;
  // ==========================================
  // Reporting and bus tasks
  task end_of_test;
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total = err_total + 1;
      end_of_test;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task wait_idle;
    do rd(`CBI_OFS_STATUS); while (v[0] | v[2]);
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    rd(`CBI_OFS_FLAGS);
    chk(v, 32'h0);
    rd(8'h20);
    chk({r, v[29:0]}, {`CBI_RESP_SLVERR, 30'h0});
    wr(8'h24, 32'h1);
    chk({30'h0, r}, {30'h0, `CBI_RESP_SLVERR});
    wr(`CBI_OFS_CTRL, 32'h1d);
    rd(`CBI_OFS_CTRL);
    chk(v, 32'h1d);
    $display("t_regs done");
  endtask
  task t_cycles;
    logic [2:0] ty [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h5};
    for (int i = 0; i < 6; i++)
    begin
      mode_select_pin <= (i != 5);
      wait_req <= (i == 3);
      rd_value <= {8'h5a, 5'h0, ty[i]};
      wr(`CBI_OFS_ADDR, 32'hf1234);
      wr(`CBI_OFS_WDATA, 32'h0c3a);
      wr(`CBI_OFS_CTRL, {23'h0, 1'b1, 3'h0, `CBI_SEG_DATA, ty[i]});
      wait_idle;
      if (ty[i] != `CBI_CYC_IOWR && ty[i] != `CBI_CYC_MEMWR)
        chk(v >> 16, {16'h0, rd_value});
    end
    wait_req <= 1'b0;
    mode_select_pin <= 1'b1;
    $display("t_cycles done");
  endtask
  task pulse_nmi;
    @(posedge sys_clk) nmi_request <= 1'b1;
    repeat (2) @(posedge sys_clk);
    nmi_request <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask
  task t_nmi;
    wr(`CBI_OFS_FLAGS, 32'h1);
    maskable_request <= 1'b1;
    rd_value <= 16'h0021;
    pulse_nmi;
    rd(`CBI_OFS_STATUS);
    chk(v & 32'h8, 32'h8);
    wr(`CBI_OFS_CTRL, 32'h200);
    rd(`CBI_OFS_VECTOR);
    chk(v, 32'h02000008);
    rd(`CBI_OFS_FLAGS);
    chk(v, 32'h2);
    wr(`CBI_OFS_CTRL, 32'h800);
    rd(`CBI_OFS_FLAGS);
    chk(v & 32'h1, 32'h1);
    wr(`CBI_OFS_CTRL, 32'h200);
    wait_idle;
    rd(`CBI_OFS_VECTOR);
    chk(v, 32'h21000084);
    rd(`CBI_OFS_FLAGS);
    chk(v & 32'h1, 32'h0);
    maskable_request <= 1'b0;
    $display("t_nmi done");
  endtask
  task t_halt;
    wr(`CBI_OFS_CTRL, 32'h400);
    repeat (8) @(posedge sys_clk);
    rd(`CBI_OFS_STATUS);
    chk(v & 32'h2, 32'h2);
    pulse_nmi;
    rd(`CBI_OFS_STATUS);
    chk(v & 32'h2, 32'h0);
    $display("t_halt done");
  endtask
  task t_rst;
    wr(`CBI_OFS_FLAGS, 32'h1);
    wr(`CBI_OFS_CTRL, 32'h105);
    repeat (2) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    wait_idle;
    rd(`CBI_OFS_FLAGS);
    chk(v, 32'h0);
    $display("t_rst done");
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    wait_idle;
    t_regs;
    t_cycles;
    t_nmi;
    t_halt;
    t_rst;
    end_of_test;
  end
endmodule // test_cbi_top
bind cbi_top cbi_monitor mon (.sys_clk, .rst, .mode_select_pin, .bus_ready,
  .ad_out, .ad_oe, .addr_status_hi, .high_byte_enable_n, .ale,
  .cycle_status_bit0, .cycle_status_bit1, .cycle_status_bit2, .mem_io_sel,
  .read_n, .write_n, .int_ack_strobe_n, .lock_n);
`default_nettype wire
